//--- src/coe_pkg.sv
package coe_pkg;
  localparam int NUM_CMP = 2;
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 8;
  // register offsets
  localparam logic [3:0] ADDR_CONTROL_0 = 4'h0; // per comparator: +index
  localparam logic [3:0] ADDR_CONTROL_1 = 4'h2;
  localparam logic [3:0] ADDR_FLAG = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  // control 0 fields
  localparam int C0_ON = 7;
  localparam int C0_INVERT = 4;
  localparam int C0_SPEED = 2;
  localparam int C0_HYST = 1;
  localparam int C0_SYNC = 0;
  // control 1 fields
  localparam int C1_RISE = 7;
  localparam int C1_FALL = 6;
  localparam int C1_PSEL_LO = 4;
  // status fields
  localparam int ST_OUT_LO = 0;
  localparam int ST_GATE_LO = 2;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {
    COE_POS_PIN,
    COE_POS_DAC,
    COE_POS_FIXED_REF,
    COE_POS_GROUND
  } coe_pos_sel_t;
endpackage

//--- src/coe_cmp_event.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module coe_cmp_event
  import coe_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [coe_pkg::REG_ADDR_W-1:0] regAddr, // register address
  input wire logic [coe_pkg::REG_DATA_W-1:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [coe_pkg::REG_DATA_W-1:0] regRdata, // read data, one cycle later
  input wire logic [coe_pkg::NUM_CMP-1:0] cmpRaw, // async analog core outputs
  input wire logic timerClkPre, // gate timer source clock after prescaler, async
  input wire logic [0:0] gateSel, // which comparator gates the timer
  output logic [coe_pkg::NUM_CMP-1:0] cmpOut, // observed comparator outputs
  output logic gateSource, // gate signal to gate timer
  output logic [coe_pkg::NUM_CMP-1:0] cmpInputEn, // analog input enables
  output logic [coe_pkg::NUM_CMP-1:0] cmpHysteresisEn, // analog hysteresis enables
  output logic [coe_pkg::NUM_CMP-1:0] cmpSpeedSel, // analog speed select
  output logic [2*coe_pkg::NUM_CMP-1:0] cmpPosInputSel, // 2 bits per comparator
  output logic [coe_pkg::NUM_CMP-1:0] riseEdge, // one-cycle rising pulse
  output logic [coe_pkg::NUM_CMP-1:0] fallEdge, // one-cycle falling pulse
  output logic [coe_pkg::NUM_CMP-1:0] cmpIrqFlag, // sticky flags
  output logic irq // level interrupt
);
  import coe_pkg::*;

  typedef struct packed {
    logic [NUM_CMP-1:0][7:0] ctrl0;
    logic [NUM_CMP-1:0][7:0] ctrl1;
    logic [NUM_CMP-1:0] flag;
    logic [NUM_CMP-1:0] mask;
    logic [NUM_CMP-1:0] raw1;
    logic [NUM_CMP-1:0] raw2;
    logic [NUM_CMP-1:0] tclk1;
    logic [NUM_CMP-1:0] tclk2;
    logic [NUM_CMP-1:0] tclkPrev;
    logic [NUM_CMP-1:0] latched;
    logic [NUM_CMP-1:0] outPrev;
    logic [NUM_CMP-1:0] rise;
    logic [NUM_CMP-1:0] fall;
    logic [7:0] rdata;
  } coe_state_t;

  coe_state_t state_reg;
  coe_state_t state_next;
  logic [NUM_CMP-1:0] observed;

  function automatic logic is_ctrl(input logic [3:0] a, input logic [3:0] base, input int i);
    is_ctrl = (a == (base + 4'(i)));
  endfunction

  // observed output: comparator off reads zero before polarity, so toggling
  // on or polarity still moves it
  generate
    for (genvar i = 0; i < NUM_CMP; i++)
    begin : g_obs
      logic core;
      assign core = state_reg.ctrl0[i][C0_ON] & state_reg.raw2[i];
      assign observed[i] = (state_reg.ctrl0[i][C0_SYNC] ? state_reg.latched[i] : core)
                           ^ state_reg.ctrl0[i][C0_INVERT];
      assign cmpInputEn[i] = state_reg.ctrl0[i][C0_ON];
      assign cmpHysteresisEn[i] = state_reg.ctrl0[i][C0_HYST];
      assign cmpSpeedSel[i] = state_reg.ctrl0[i][C0_SPEED];
      assign cmpPosInputSel[2*i +: 2] = state_reg.ctrl1[i][C1_PSEL_LO +: 2];
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    state_next.raw1 = cmpRaw;
    state_next.raw2 = state_reg.raw1;
    state_next.tclk1 = {NUM_CMP{timerClkPre}};
    state_next.tclk2 = state_reg.tclk1;
    state_next.tclkPrev = state_reg.tclk2;
    state_next.rdata = ZERO_BYTE;
    for (int i = 0; i < NUM_CMP; i++)
    begin
      // latch on the falling edge of the prescaled timer clock; the timer itself
      // counts on the rising edge, so the gate is stable when it counts
      if (state_reg.tclkPrev[i] && !state_reg.tclk2[i])
      begin
        state_next.latched[i] = state_reg.ctrl0[i][C0_ON] & state_reg.raw2[i];
      end
      state_next.outPrev[i] = observed[i];
      state_next.rise[i] = observed[i] & ~state_reg.outPrev[i];
      state_next.fall[i] = ~observed[i] & state_reg.outPrev[i];
    end
    if (regWr)
    begin
      for (int i = 0; i < NUM_CMP; i++)
      begin
        if (is_ctrl(regAddr, ADDR_CONTROL_0, i))
        begin
          state_next.ctrl0[i] = regWdata;
        end
        else if (is_ctrl(regAddr, ADDR_CONTROL_1, i))
        begin
          state_next.ctrl1[i] = regWdata;
        end
      end
      if (regAddr == ADDR_FLAG)
      begin
        state_next.flag = regWdata[NUM_CMP-1:0];
      end
      else if (regAddr == ADDR_MASK)
      begin
        state_next.mask = regWdata[NUM_CMP-1:0];
      end
    end
    if (regRd)
    begin
      for (int i = 0; i < NUM_CMP; i++)
      begin
        if (is_ctrl(regAddr, ADDR_CONTROL_0, i))
        begin
          state_next.rdata = state_reg.ctrl0[i];
        end
        else if (is_ctrl(regAddr, ADDR_CONTROL_1, i))
        begin
          state_next.rdata = state_reg.ctrl1[i];
        end
      end
      if (regAddr == ADDR_FLAG)
      begin
        state_next.rdata[NUM_CMP-1:0] = state_reg.flag;
        // read clears, but a same-cycle set survives below
        state_next.flag = '0;
      end
      else if (regAddr == ADDR_MASK)
      begin
        state_next.rdata[NUM_CMP-1:0] = state_reg.mask;
      end
      else if (regAddr == ADDR_STATUS)
      begin
        state_next.rdata[ST_OUT_LO +: NUM_CMP] = observed;
        state_next.rdata[ST_GATE_LO] = gateSource;
      end
    end
    // set applied last so it beats any clear
    for (int i = 0; i < NUM_CMP; i++)
    begin
      if ((state_reg.rise[i] && state_reg.ctrl1[i][C1_RISE])
          || (state_reg.fall[i] && state_reg.ctrl1[i][C1_FALL]))
      begin
        state_next.flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
      for (int i = 0; i < NUM_CMP; i++)
      begin
        state_reg.ctrl0[i] <= CTRL0_RESET;
        state_reg.ctrl1[i] <= CTRL1_RESET;
      end
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign cmpOut = observed;
  assign gateSource = observed[gateSel];
  assign riseEdge = state_reg.rise;
  assign fallEdge = state_reg.fall;
  assign cmpIrqFlag = state_reg.flag;
  assign irq = |(state_reg.flag & state_reg.mask);
  assign regRdata = state_reg.rdata;
endmodule

//--- bench/coe_cmp_event_assertions.sv
`timescale 1ns/1ps
module coe_chk
  import coe_pkg::*;
(
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic [coe_pkg::REG_ADDR_W-1:0] regAddr, // address
  input wire logic regWr, // write
  input wire logic regRd, // read
  input wire logic [0:0] gateSel, // gate pick
  input wire logic gateSource, // gate
  input wire logic [coe_pkg::NUM_CMP-1:0] cmpOut, // outputs
  input wire logic [coe_pkg::NUM_CMP-1:0] riseEdge, // rise
  input wire logic [coe_pkg::NUM_CMP-1:0] fallEdge, // fall
  input wire logic [coe_pkg::NUM_CMP-1:0] cmpIrqFlag, // flags
  input wire logic irq // interrupt
);
  logic flagAcc;
  assign flagAcc = (regWr || regRd) && regAddr == ADDR_FLAG;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rise_pulse: assert property ($rose(cmpOut[0]) |=> riseEdge[0])
    else $error("rise missing");
  a_fall_pulse: assert property ($fell(cmpOut[0]) |=> fallEdge[0])
    else $error("fall missing");
  a_pulse_single: assert property (riseEdge[0] |=> !riseEdge[0])
    else $error("long pulse");
  a_flag_sticky: assert property (cmpIrqFlag[0] && !flagAcc |=> cmpIrqFlag[0])
    else $error("flag lost");
  a_flag_cause: assert property ($rose(cmpIrqFlag[0]) |-> $past(riseEdge[0] | fallEdge[0] | regWr))
    else $error("flag without edge");
  a_read_clears: assert property (regRd && flagAcc && !riseEdge[0] && !fallEdge[0] |=> !cmpIrqFlag[0])
    else $error("flag not cleared");
  a_irq_needs_flag: assert property (irq |-> |cmpIrqFlag)
    else $error("irq without flag");
  a_gate_route: assert property (gateSource == cmpOut[gateSel])
    else $error("gate route");
  c_rise: cover property (riseEdge[0]);
  c_fall: cover property (fallEdge[0]);
  c_irq: cover property (irq);
endmodule
bind coe_cmp_event coe_chk i_chk(.clk, .resetn, .regAddr, .regWr, .regRd, .gateSel,
  .gateSource, .cmpOut, .riseEdge, .fallEdge, .cmpIrqFlag, .irq);

//--- bench/coe_analog_model.sv
`timescale 1ns/1ps
module coe_analog_model
(
  input wire logic run, // timer clock runs
  input wire logic [1:0] level, // analog decisions
  input wire logic [1:0] inEn, // input enables
  output logic [1:0] raw, // core outputs
  output logic tclk // prescaled timer clock
);
  // a disabled core sees no input, so it cannot decide high
  assign raw = level & inEn;
  initial tclk = 1'b0;
  // prescaled clock, unrelated in phase, still while stopped
  always #35 if (run) tclk = ~tclk;
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import coe_pkg::*;
  logic clk, resetn, regWr, regRd, run, tclk, gateSource, irq;
  logic [3:0] regAddr, psel;
  logic [7:0] regWdata, regRdata;
  logic [1:0] raw, cmpOut, inEn, hyst, spd, rise, fall, flag, level;
  logic [0:0] gateSel;
  int n_mismatch = 0, checks = 0, cyc = 0;
  coe_cmp_event i_dut(.clk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .cmpRaw(raw), .timerClkPre(tclk), .gateSel, .cmpOut, .gateSource, .cmpInputEn(inEn),
    .cmpHysteresisEn(hyst), .cmpSpeedSel(spd), .cmpPosInputSel(psel), .riseEdge(rise),
    .fallEdge(fall), .cmpIrqFlag(flag), .irq);
  coe_analog_model i_ana(.run, .level, .inEn, .raw, .tclk);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a hang is cut short well beyond the roughly 155 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 0;
    #1 chk(regRdata, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial
  begin
    {resetn, regWr, regRd, regAddr, regWdata, run, level, gateSel} = '0;
    repeat (8) @(posedge clk);
    resetn <= 1;
    wr(ADDR_CONTROL_1, 8'hC0);
    wr(ADDR_MASK, 8'h03);
    wr(ADDR_CONTROL_0, 8'h80);
    level <= 2'b01;
    idle(10);
    chk(irq, 1);
    rd(ADDR_FLAG, 8'h01);
    rd(ADDR_FLAG, 8'h00);
    wr(ADDR_CONTROL_1, 8'h80);
    level <= 2'b00;
    idle(10);
    rd(ADDR_FLAG, 8'h00);
    wr(ADDR_CONTROL_1, 8'h40);
    wr(ADDR_CONTROL_0, 8'h10);
    idle(4);
    rd(ADDR_FLAG, 8'h00);
    wr(ADDR_CONTROL_0, 8'h00);
    idle(4);
    rd(ADDR_FLAG, 8'h01);
    wr(ADDR_CONTROL_0, 8'h81);
    level <= 2'b01;
    idle(12);
    chk(cmpOut[0], 0);
    run = 1;
    idle(40);
    chk(cmpOut[0], 1);
    run = 0;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CONTROL_1 + 4'h1, {2'h0, i[1:0], 4'h0});
      idle(1);
      chk(psel[3:2], i[7:0]);
    end
    wr(ADDR_CONTROL_0 + 4'h1, 8'h06);
    idle(1);
    chk({inEn, hyst[1], spd[1]}, 8'h07);
    @(posedge clk) gateSel <= 1'b1;
    idle(1);
    chk(gateSource, 0);
    @(posedge clk) gateSel <= 1'b0;
    idle(1);
    chk(gateSource, 1);
    wr(ADDR_CONTROL_1 + 4'h1, 8'hC0);
    // the clear lands on the very edge that the invert toggle sets the flag
    wr(ADDR_CONTROL_0 + 4'h1, 8'h16);
    wr(ADDR_FLAG, 8'h00);
    idle(2);
    chk(irq, 1);
    wr(ADDR_MASK, 8'h01);
    idle(1);
    chk(irq, 0);
    rd(ADDR_FLAG, 8'h02);
    rd(ADDR_STATUS, 8'h07);
    rd(ADDR_CONTROL_0, 8'h81);
    rd(ADDR_CONTROL_1 + 4'h1, 8'hC0);
    rd(4'hF, 8'h00);
    report_and_stop;
  end
endmodule
